/* File: design/dsv_map.svh */
// Purpose: Register offsets, field positions and reset values
// Assumes: Included by the volume stage modules and the testbench
// Notes: Offsets are word indices on the plain register port
`ifndef DSV_MAP_SVH
`define DSV_MAP_SVH
`define DSV_ADDR_W 4
`define DSV_REG_LVOL 4'h0
`define DSV_REG_RVOL 4'h1
`define DSV_REG_MASTER 4'h2
`define DSV_REG_CTRL 4'h3
`define DSV_REG_PWR 4'h4
`define DSV_REG_STAT 4'h5
`define DSV_REG_ISTAT 4'h6
`define DSV_REG_IMASK 4'h7
`define DSV_REG_GAIN 4'h8
`define DSV_VOL_MUTE 7
`define DSV_CTRL_SLOW 0
`define DSV_CTRL_NOSTEP 1
`define DSV_CTRL_DEEMPH 2
`define DSV_CTRL_EFFECT 3
`define DSV_PWR_DAC 0
`define DSV_PWR_LANA 1
`define DSV_PWR_RANA 2
`define DSV_STAT_DONE 0
`define DSV_STAT_PDFLAG 1
`define DSV_STAT_MUTED 2
`define DSV_IRQ_DONE 0
`define DSV_IRQ_PD 1
`define DSV_IRQ_FX 2
`define DSV_IRQ_W 3
`define DSV_VOL_RST 8'h00
`define DSV_ATT_FULL 7'h7F
`define DSV_ATT_ZERO 7'h00
`endif

/* File: design/dsv_pkg.sv */
// Purpose: Types shared by the soft-step volume stage
// Assumes: State numbers are literal here, not taken from the map header
// Notes: Sequencer state encoding only
package dsv_pkg;
    typedef enum logic [2:0] {
        DSV_OFF = 3'h0,
        DSV_UP = 3'h1,
        DSV_RUN = 3'h2,
        DSV_FX_DOWN = 3'h3,
        DSV_PD_DOWN = 3'h4,
        DSV_PD_DONE = 3'h5
    } dsv_seq_t;
endpackage

/* File: design/dsv_gain_ch.sv */
// Purpose: One channel of soft-stepped attenuation and sample scaling
// Assumes: Attenuation code counts half-decibel steps, 127 is full cut
// Notes: Output registered, one clock of latency
`timescale 1ns/1ns
`include "dsv_map.svh"
module dsv_gain_ch #(
    parameter int DATA_W = 24
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic step_en,
    input wire logic [6:0] target_att,
    input wire logic no_step,
    input wire logic sample_valid,
    input wire logic signed [DATA_W-1:0] sample_in,
    output logic [6:0] applied_att,
    output logic signed [DATA_W-1:0] sample_out,
    output logic at_target
);
    initial
    begin
        if (DATA_W < 8 || DATA_W > 32)
            $error("DATA_W out of range");
    end

    // Mantissa of 10^(-k/40) in Q15, half-decibel steps, for one 6 dB octave
    function automatic logic [15:0] frac_gain(input logic [3:0] k);
        case (k)
            4'h0: frac_gain = 16'h8000;
            4'h1: frac_gain = 16'h78D6;
            4'h2: frac_gain = 16'h7214;
            4'h3: frac_gain = 16'h6BB2;
            4'h4: frac_gain = 16'h65AC;
            4'h5: frac_gain = 16'h5FFC;
            4'h6: frac_gain = 16'h5A9E;
            4'h7: frac_gain = 16'h558C;
            4'h8: frac_gain = 16'h50C3;
            4'h9: frac_gain = 16'h4C3E;
            4'hA: frac_gain = 16'h47FA;
            4'hB: frac_gain = 16'h43F4;
            default: frac_gain = 16'h8000;
        endcase
    endfunction

    logic [6:0] att_r;
    logic [6:0] att_nxt;
    logic signed [DATA_W-1:0] out_r;
    wire logic [3:0] octave = 4'(att_r / 7'd12);
    wire logic [3:0] frac_k = 4'(att_r % 7'd12);
    wire logic signed [16:0] coef = $signed({1'b0, frac_gain(frac_k)});
    wire logic signed [DATA_W+16:0] prod = sample_in * coef;
    wire logic signed [DATA_W+16:0] shifted = prod >>> (5'd15 + 5'(octave));
    wire logic full_cut = (att_r == `DSV_ATT_FULL);

    always_comb
    begin
        att_nxt = att_r;
        if (no_step)
            att_nxt = target_att;
        else if (step_en && att_r < target_att)
            att_nxt = att_r + 7'd1;
        else if (step_en && att_r > target_att)
            att_nxt = att_r - 7'd1;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            att_r <= `DSV_ATT_FULL;
            out_r <= '0;
        end
        else
        begin
            att_r <= att_nxt;
            if (sample_valid)
                out_r <= full_cut ? '0 : shifted[DATA_W-1:0];
        end
    end

    assign applied_att = att_r;
    assign sample_out = out_r;
    assign at_target = (att_r == target_att);
endmodule // dsv_gain_ch

/* File: design/dsv_volume.sv */
// Purpose: Stereo soft-step digital volume stage in front of a DAC
// Assumes: Samples arrive with a valid strobe on core_clk
// Notes: Plain register port, read data one cycle after the strobe
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "dsv_map.svh"
module dsv_volume
    import dsv_pkg::*;
#(
    parameter int DATA_W = 24
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [`DSV_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic signed [DATA_W-1:0] left_in,
    input wire logic signed [DATA_W-1:0] right_in,
    output logic sample_out_valid,
    output logic signed [DATA_W-1:0] left_out,
    output logic signed [DATA_W-1:0] right_out,
    output logic deemph_on,
    output logic effect_on,
    output logic dac_power,
    output logic left_ana_power,
    output logic right_ana_power,
    output logic irq
);
    import dsv_pkg::*;

    initial
    begin
        if (DATA_W < 8 || DATA_W > 32)
            $error("DATA_W out of range");
    end

    logic [7:0] lvol_r;
    logic [7:0] rvol_r;
    logic [3:0] ctrl_r;
    logic [2:0] pwr_r;
    logic [`DSV_IRQ_W-1:0] istat_r;
    logic [`DSV_IRQ_W-1:0] imask_r;
    logic [7:0] rdata_r;
    logic [1:0] fx_applied_r;
    logic pd_flag_r;
    logic done_r;
    logic half_r;
    logic valid_r;
    logic irq_r;
    logic lmuted_r;
    logic rmuted_r;
    logic lana_r;
    logic rana_r;
    logic dacp_r;
    dsv_seq_t seq_r;
    dsv_seq_t seq_nxt;

    wire logic [6:0] latt;
    wire logic [6:0] ratt;
    wire logic signed [DATA_W-1:0] lsamp;
    wire logic signed [DATA_W-1:0] rsamp;
    wire logic lat;
    wire logic rat;

    // Register decode
    wire logic wr_lvol = reg_wr && reg_addr == `DSV_REG_LVOL;
    wire logic wr_rvol = reg_wr && reg_addr == `DSV_REG_RVOL;
    wire logic wr_master = reg_wr && reg_addr == `DSV_REG_MASTER;
    wire logic wr_ctrl = reg_wr && reg_addr == `DSV_REG_CTRL;
    wire logic wr_pwr = reg_wr && reg_addr == `DSV_REG_PWR;
    wire logic wr_istat = reg_wr && reg_addr == `DSV_REG_ISTAT;
    wire logic wr_imask = reg_wr && reg_addr == `DSV_REG_IMASK;

    wire logic slow = ctrl_r[`DSV_CTRL_SLOW];
    wire logic no_step = ctrl_r[`DSV_CTRL_NOSTEP];
    wire logic pwr_req = pwr_r[`DSV_PWR_DAC];
    wire logic fx_change = (ctrl_r[`DSV_CTRL_EFFECT:`DSV_CTRL_DEEMPH] != fx_applied_r);

    wire logic step_en = sample_valid && (!slow || half_r);

    // Sequencer forces full cut while off, while muting down and in DSV_PD_DONE
    wire logic force_cut = (seq_r == DSV_OFF) || (seq_r == DSV_FX_DOWN)
        || (seq_r == DSV_PD_DOWN) || (seq_r == DSV_PD_DONE);
    // Ramp to full cut when muted
    wire logic [6:0] ltgt = (force_cut || lvol_r[`DSV_VOL_MUTE]) ? `DSV_ATT_FULL : lvol_r[6:0];
    wire logic [6:0] rtgt = (force_cut || rvol_r[`DSV_VOL_MUTE]) ? `DSV_ATT_FULL : rvol_r[6:0];
    // Both channels silenced at a sample boundary
    wire logic both_quiet = lmuted_r && rmuted_r;
    wire logic all_at = lat && rat;

    dsv_gain_ch #(.DATA_W(DATA_W)) u_left (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .step_en(step_en),
        .target_att(ltgt),
        .no_step(no_step),
        .sample_valid(sample_valid),
        .sample_in(left_in),
        .applied_att(latt),
        .sample_out(lsamp),
        .at_target(lat)
    );

    dsv_gain_ch #(.DATA_W(DATA_W)) u_right (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .step_en(step_en),
        .target_att(rtgt),
        .no_step(no_step),
        .sample_valid(sample_valid),
        .sample_in(right_in),
        .applied_att(ratt),
        .sample_out(rsamp),
        .at_target(rat)
    );

    // Sequencer for power and effect changes
    always_comb
    begin
        seq_nxt = seq_r;
        case (seq_r)
            DSV_OFF:
                if (pwr_req)
                    seq_nxt = DSV_UP;
            DSV_UP:
                if (!pwr_req)
                    seq_nxt = DSV_PD_DOWN;
                else
                    seq_nxt = DSV_RUN;
            DSV_RUN:
                if (!pwr_req)
                    seq_nxt = DSV_PD_DOWN;
                else if (fx_change)
                    seq_nxt = DSV_FX_DOWN;
            DSV_FX_DOWN:
                if (both_quiet)
                    seq_nxt = DSV_RUN;
            DSV_PD_DOWN:
                if (both_quiet)
                    seq_nxt = DSV_PD_DONE;
            DSV_PD_DONE:
                seq_nxt = DSV_OFF;
            default:
                seq_nxt = DSV_OFF;
        endcase
    end

    wire logic fx_apply = (seq_r == DSV_FX_DOWN) && both_quiet;
    wire logic pd_finish = (seq_r == DSV_PD_DONE);
    wire logic [`DSV_IRQ_W-1:0] ev;
    assign ev[`DSV_IRQ_DONE] = all_at && !done_r;
    assign ev[`DSV_IRQ_PD] = pd_finish;
    assign ev[`DSV_IRQ_FX] = fx_apply;

    wire logic [7:0] stat_val = {5'h00, lmuted_r && rmuted_r, pd_flag_r, done_r};
    wire logic [7:0] rd_mux =
        (reg_addr == `DSV_REG_LVOL) ? lvol_r :
        (reg_addr == `DSV_REG_RVOL) ? rvol_r :
        (reg_addr == `DSV_REG_MASTER) ? lvol_r :
        (reg_addr == `DSV_REG_CTRL) ? {4'h0, ctrl_r} :
        (reg_addr == `DSV_REG_PWR) ? {5'h00, pwr_r} :
        (reg_addr == `DSV_REG_STAT) ? stat_val :
        (reg_addr == `DSV_REG_ISTAT) ? {5'h00, istat_r} :
        (reg_addr == `DSV_REG_IMASK) ? {5'h00, imask_r} :
        (reg_addr == `DSV_REG_GAIN) ? {1'b0, latt} : 8'h00;

    // Software registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lvol_r <= `DSV_VOL_RST;
            rvol_r <= `DSV_VOL_RST;
            ctrl_r <= 4'h0;
            pwr_r <= 3'h0;
            imask_r <= '0;
        end
        else
        begin
            if (wr_lvol || wr_master)
                lvol_r <= reg_wdata;
            if (wr_rvol || wr_master)
                rvol_r <= reg_wdata;
            if (wr_ctrl)
                ctrl_r <= reg_wdata[3:0];
            if (wr_pwr)
                pwr_r <= reg_wdata[2:0];
            if (wr_imask)
                imask_r <= reg_wdata[`DSV_IRQ_W-1:0];
        end
    end

    // Status, interrupt and read data
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            istat_r <= '0;
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
            done_r <= 1'b0;
            pd_flag_r <= 1'b1;
        end
        else
        begin
            // Set wins over write-one clear
            istat_r <= (istat_r & ~(wr_istat ? reg_wdata[`DSV_IRQ_W-1:0] : '0)) | ev;
            irq_r <= |(istat_r & imask_r);
            rdata_r <= reg_rd ? rd_mux : 8'h00;
            done_r <= all_at;
            if (pd_finish)
                pd_flag_r <= 1'b1;
            else if (seq_r == DSV_UP)
                pd_flag_r <= 1'b0;
        end
    end

    // Datapath and power outputs
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fx_applied_r <= 2'h0;
            half_r <= 1'b0;
            valid_r <= 1'b0;
            lmuted_r <= 1'b1;
            rmuted_r <= 1'b1;
            dacp_r <= 1'b0;
            lana_r <= 1'b0;
            rana_r <= 1'b0;
        end
        else
        begin
            if (fx_apply || seq_r == DSV_OFF)
                fx_applied_r <= ctrl_r[`DSV_CTRL_EFFECT:`DSV_CTRL_DEEMPH];
            if (sample_valid)
                half_r <= ~half_r;
            valid_r <= sample_valid;
            if (sample_valid)
            begin
                lmuted_r <= latt == `DSV_ATT_FULL && ltgt == `DSV_ATT_FULL;
                rmuted_r <= ratt == `DSV_ATT_FULL && rtgt == `DSV_ATT_FULL;
            end
            dacp_r <= (seq_r != DSV_OFF) && (seq_r != DSV_PD_DONE);
            lana_r <= pwr_r[`DSV_PWR_LANA] && (seq_r != DSV_OFF);
            rana_r <= pwr_r[`DSV_PWR_RANA] && (seq_r != DSV_OFF);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            seq_r <= DSV_OFF;
        else
            seq_r <= seq_nxt;
    end

    assign reg_rdata = rdata_r;
    assign sample_out_valid = valid_r;
    assign left_out = lsamp;
    assign right_out = rsamp;
    assign deemph_on = fx_applied_r[0];
    assign effect_on = fx_applied_r[1];
    assign dac_power = dacp_r;
    assign left_ana_power = lana_r;
    assign right_ana_power = rana_r;
    assign irq = irq_r;
endmodule // dsv_volume

/* File: verif/dsv_volume_chk.sv */
// Purpose: Port checks for the soft-step volume stage
// Assumes: Bound to every dsv_volume instance
// Notes: Sees top-level ports only
`timescale 1ns/1ns
module dsv_volume_chk #(
    parameter int DATA_W = 24
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic signed [DATA_W-1:0] left_in,
    input wire logic signed [DATA_W-1:0] right_in,
    input wire logic sample_out_valid,
    input wire logic signed [DATA_W-1:0] left_out,
    input wire logic signed [DATA_W-1:0] right_out,
    input wire logic deemph_on,
    input wire logic effect_on,
    input wire logic dac_power,
    input wire logic left_ana_power,
    input wire logic right_ana_power,
    input wire logic irq
);
    wire logic quiet = ~|left_out && ~|right_out;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    a_out_valid_lag: assert property (sample_valid |=> sample_out_valid)
        else $error("output valid missing");
    a_no_extra_valid: assert property (!sample_valid |=> !sample_out_valid)
        else $error("output valid without sample");
    a_out_hold: assert property (!sample_valid |=> $stable(left_out) && $stable(right_out))
        else $error("output moved between samples");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_dac_off_quiet: assert property (!dac_power |-> quiet)
        else $error("output while dac off");
    a_fx_switch_muted: assert property ($changed(effect_on) || $changed(deemph_on) |-> quiet)
        else $error("filter switched while audible");
    a_power_up_muted: assert property ($rose(dac_power) |-> quiet ##1 quiet)
        else $error("power-up not muted");
    a_ana_drop: assert property ($fell(dac_power) |-> ##[0:2] !(left_ana_power || right_ana_power))
        else $error("analog power left on");
    cover property ($rose(dac_power));
    cover property ($changed(effect_on));
    cover property ($rose(irq));
endmodule // dsv_volume_chk

bind dsv_volume dsv_volume_chk #(.DATA_W(DATA_W)) i_chk (.core_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid, .left_in, .right_in,
    .sample_out_valid, .left_out, .right_out, .deemph_on, .effect_on, .dac_power,
    .left_ana_power, .right_ana_power, .irq);

/* File: verif/dsv_src.sv */
// Purpose: Sample source model on the far side
// Assumes: One sample every eight clocks while run is high
// Notes: Constant data, left and right differ
`timescale 1ns/1ns
module dsv_src (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic run,
    output logic sample_valid,
    output logic signed [23:0] left_in,
    output logic signed [23:0] right_in
);
    logic [2:0] cnt_r;
    assign left_in = 24'h200000;
    assign right_in = 24'hE80000;
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_r <= 3'h0;
            sample_valid <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 3'h1;
            sample_valid <= run && cnt_r == 3'h7;
        end
    end
endmodule // dsv_src

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the soft-step volume stage
// Assumes: Register port with read data one cycle after the strobe
// Notes: Gain read back through the applied gain register
`timescale 1ns/1ns
`include "dsv_map.svh"
module testbench;
    logic core_clk, reset_n, run, reg_wr, reg_rd, sample_valid, sample_out_valid, irq;
    logic deemph_on, effect_on, dac_power, left_ana_power, right_ana_power;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic signed [23:0] left_in, right_in, left_out, right_out;
    int err_count = 0;
    int compares = 0;
    dsv_src i_src (.core_clk, .reset_n, .run, .sample_valid, .left_in, .right_in);
    dsv_volume #(.DATA_W(24)) i_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .sample_valid, .left_in, .right_in, .sample_out_valid,
        .left_out, .right_out, .deemph_on, .effect_on, .dac_power, .left_ana_power,
        .right_ana_power, .irq);
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic end_sim;
        begin
            if (err_count == 0 && compares > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        begin
            compares++;
            if (g !== e)
            begin
                err_count++;
                $display("wrong value at %0t: got %h exp %h", $time, g, e);
            end
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 chk({16'h0000, reg_rdata & m}, {16'h0000, e & m});
            @(posedge core_clk);
        end
    endtask
    task automatic wsamp(input int n);
        int k;
        begin
            for (k = 0; k < 9000 && n > 0; k++)
            begin
                @(posedge core_clk);
                if (sample_valid)
                    n--;
            end
            if (n > 0)
                chk(24'h000001, 24'h000000);
        end
    endtask
    task automatic wsig(input int s, input logic v);
        int k;
        begin
            for (k = 0; k < 9000 && (s == 0 ? effect_on : s == 1 ? deemph_on : dac_power) !== v; k++)
                @(posedge core_clk);
            if (k == 9000)
                chk(24'h000001, 24'h000000);
        end
    endtask
    initial
    begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        run = 1'b0;
        reset_n = 1'b0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(`DSV_REG_STAT, 8'h02, 8'h02);
        rd(`DSV_REG_LVOL, `DSV_VOL_RST, 8'hFF);
        rd(4'hF, 8'h00, 8'hFF);
        wr(`DSV_REG_IMASK, 8'h03);
        wr(`DSV_REG_MASTER, 8'h0A);
        rd(`DSV_REG_RVOL, 8'h0A, 8'hFF);
        wr(4'hF, 8'h55);
        rd(`DSV_REG_LVOL, 8'h0A, 8'hFF);
        wr(`DSV_REG_PWR, 8'h07);
        repeat (2) @(posedge core_clk);
        chk({21'h0, dac_power, left_ana_power, right_ana_power}, 24'h7);
        rd(`DSV_REG_GAIN, `DSV_ATT_FULL, 8'hFF);
        run <= 1'b1;
        wsamp(5);
        rd(`DSV_REG_GAIN, 8'h7A, 8'hFF);
        wr(`DSV_REG_CTRL, 8'h01);
        wsamp(4);
        rd(`DSV_REG_GAIN, 8'h78, 8'hFF);
        wr(`DSV_REG_CTRL, 8'h02);
        wsamp(1);
        rd(`DSV_REG_GAIN, 8'h0A, 8'hFF);
        rd(`DSV_REG_STAT, 8'h01, 8'h01);
        rd(`DSV_REG_ISTAT, 8'h01, 8'h01);
        chk({23'h0, irq}, 24'h1);
        wr(`DSV_REG_IMASK, 8'h00);
        @(posedge core_clk);
        chk({23'h0, irq}, 24'h0);
        wr(`DSV_REG_ISTAT, 8'h01);
        rd(`DSV_REG_ISTAT, 8'h00, 8'h01);
        wr(`DSV_REG_IMASK, 8'h03);
        wsamp(1);
        wr(`DSV_REG_CTRL, 8'h00);
        wr(`DSV_REG_LVOL, 8'h14);
        wsamp(3);
        rd(`DSV_REG_GAIN, 8'h0D, 8'hFF);
        rd(`DSV_REG_STAT, 8'h00, 8'h01);
        wr(`DSV_REG_CTRL, 8'h02);
        wr(`DSV_REG_LVOL, 8'h80);
        wsamp(2);
        chk({23'h0, left_out === 24'h0, right_out === 24'h0}, 24'h2);
        chk(right_out, 24'hF28120);
        wr(`DSV_REG_LVOL, 8'h0A);
        wr(`DSV_REG_CTRL, 8'h08);
        wsig(0, 1'b1);
        rd(`DSV_REG_ISTAT, 8'h04, 8'h04);
        wsamp(130);
        rd(`DSV_REG_GAIN, 8'h0A, 8'hFF);
        wr(`DSV_REG_CTRL, 8'h0C);
        wsig(1, 1'b1);
        wr(`DSV_REG_PWR, 8'h00);
        wsig(2, 1'b0);
        rd(`DSV_REG_GAIN, `DSV_ATT_FULL, 8'hFF);
        rd(`DSV_REG_STAT, 8'h02, 8'h02);
        rd(`DSV_REG_ISTAT, 8'h02, 8'h02);
        chk({23'h0, irq}, 24'h1);
        end_sim();
    end
endmodule // testbench
